// ### design/fses_pkg.sv
// Package of command codes, register offsets and timing counts for the flash host sequencer.
package fses_pkg;
    // ======================================================================
    // Command codes and unlock cycles.
    localparam logic [7:0]  CMD_UNLOCK1     = 8'haa;
    localparam logic [7:0]  CMD_UNLOCK2     = 8'h55;
    localparam logic [7:0]  CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0]  CMD_CHIP_ERASE  = 8'h10;
    localparam logic [7:0]  CMD_SECT_ERASE  = 8'h30;
    localparam logic [7:0]  CMD_PROG_SUSP   = 8'h51;
    localparam logic [7:0]  CMD_PROG_RESUME = 8'h50;
    localparam logic [7:0]  CMD_COMB_SUSP   = 8'hb0;
    localparam logic [7:0]  CMD_COMB_RESUME = 8'h30;
    localparam logic [7:0]  CMD_ID_ENTER    = 8'h90;
    localparam logic [7:0]  CMD_RESET       = 8'hf0;
    localparam logic [21:0] ADDR_UNLOCK1    = 22'h000555;
    localparam logic [21:0] ADDR_UNLOCK2    = 22'h0002aa;
    localparam int          UNLOCK_CYCLES   = 6;
    // ======================================================================
    // Software register offsets.
    localparam logic [3:0]  REG_CTRL   = 4'h0;
    localparam logic [3:0]  REG_ADDR   = 4'h1;
    localparam logic [3:0]  REG_STATUS = 4'h2;
    localparam logic [3:0]  REG_RDATA  = 4'h3;
    // Command field of the control register.
    localparam logic [2:0]  OP_NONE    = 3'h0;
    localparam logic [2:0]  OP_CHIP    = 3'h1;
    localparam logic [2:0]  OP_SECTOR  = 3'h2;
    localparam logic [2:0]  OP_ADD_SEC = 3'h3;
    localparam logic [2:0]  OP_SUSPEND = 3'h4;
    localparam logic [2:0]  OP_RESUME  = 3'h5;
    localparam logic [2:0]  OP_READ    = 3'h6;
    localparam logic [2:0]  OP_HWRESET = 3'h7;
    // Status bit positions in a data word.
    localparam int          BIT_POLL   = 7;
    localparam int          BIT_TOGGLE = 6;
    localparam int          BIT_TIMER  = 3;
    localparam int          BIT_ERTOG  = 2;
    // ======================================================================
    // Timing.
    localparam int          CLK_PERIOD_PS       = 5000;
    localparam int          BUS_CYCLE_NS        = 70;
    localparam int          BUS_CYCLES          =
        (BUS_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          RESET_PULSE_NS      = 500;
    localparam int          RESET_CYCLES        =
        (RESET_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          SECT_GAP_US         = 50;
    localparam int          SECT_GAP_CYCLES     = (SECT_GAP_US * 1000000) / CLK_PERIOD_PS - 1;
    localparam int          RES_TO_SUSP_US      = 100;
    localparam int          RES_TO_SUSP_CYCLES  =
        (RES_TO_SUSP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage

// ### design/fses_sync.sv
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/10ps
module fses_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta;

    // Two stages; only the second reads the first.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta <= '0;
            q_o  <= '0;
        end else if (ce_i) begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule

// ### design/fses_timer.sv
// Loadable down counter used for the sector-add window and the resume-to-suspend guard.
`timescale 1ns/10ps
module fses_timer #(
    parameter int W = 24
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] value_i,
    output logic              done_o
);
    logic [W-1:0] count;
    logic [W-1:0] next_count;

    // Load wins over counting down.
    always_comb begin
        next_count = count;
        if (load_i) begin
            next_count = value_i;
        end else if (count != '0) begin
            next_count = count - 1'b1;
        end
    end

    // Registers the count.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count <= '0;
        end else if (ce_i) begin
            count <= next_count;
        end
    end

    assign done_o = (count == '0);
endmodule

// ### design/fses_host.sv
// Host controller that drives erase and program suspend sequences into a parallel flash.
`timescale 1ns/10ps
module fses_host
    import fses_pkg::*;
#(
    parameter int AW        = 22,
    parameter int DW        = 16,
    parameter int SECT_GAP  = SECT_GAP_CYCLES,
    parameter int RES_GUARD = RES_TO_SUSP_CYCLES
) (
    input  wire logic          sys_clk_i,
    input  wire logic          rst_i,
    input  wire logic          ce_i,
    // Software port.
    input  wire logic [3:0]    sw_addr_i,
    input  wire logic [31:0]   sw_wdata_i,
    input  wire logic          sw_wr_i,
    input  wire logic          sw_rd_i,
    output logic      [31:0]   sw_rdata_o,
    // Flash pins.
    output logic      [AW-1:0] fl_addr_o,
    output logic      [DW-1:0] fl_dq_o,
    output logic               fl_dq_oe_o,
    input  wire logic [DW-1:0] fl_dq_i,
    output logic               fl_we_n_o,
    output logic               fl_oe_n_o,
    output logic               fl_ce_n_o,
    output logic               fl_reset_n_o,
    input  wire logic          fl_ready_i
);
    import fses_pkg::*;

    typedef enum {
        ST_IDLE, ST_WRITE, ST_READ, ST_RESET, ST_BUSY
    } fses_state_t;

    // ======================================================================
    // Pin synchronisers.
    logic [DW-1:0] dq_sync;
    logic          ready_sync;

    fses_sync #(.W(DW + 1)) u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .d_i       ({fl_ready_i, fl_dq_i}),
        .q_o       ({ready_sync, dq_sync})
    );

    // ======================================================================
    // Sequencer state.
    fses_state_t   state, next_state;
    logic [2:0]    op, next_op;
    logic [2:0]    step, next_step;
    logic [7:0]    cyc, next_cyc;
    logic [AW-1:0] addr_reg, next_addr_reg;
    logic [AW-1:0] sect, next_sect;
    logic [DW-1:0] rdata, next_rdata;
    logic [AW-1:0] next_fl_addr;
    logic [DW-1:0] next_fl_dq;
    logic          next_we_n, next_oe_n, next_dq_oe, next_reset_n;
    logic          in_window, next_in_window;
    logic          err, next_err;
    logic          resumed, next_resumed;
    logic          gap_load, gap_done, guard_load, guard_done;

    // Window timer: reloaded at the end of the final write of each sector erase or added sector.
    fses_timer #(.W(24)) u_gap (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .load_i    (gap_load),
        .value_i   (24'(SECT_GAP)),
        .done_o    (gap_done)
    );

    // Resume-to-suspend guard timer.
    fses_timer #(.W(24)) u_guard (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .load_i    (guard_load),
        .value_i   (24'(RES_GUARD)),
        .done_o    (guard_done)
    );

    logic sw_ctrl_wr;
    logic [2:0] sw_op;
    logic last_write;
    logic [AW-1:0] cyc_addr;
    logic [7:0]    cyc_data;
    logic          idle_ok;

    assign sw_ctrl_wr = sw_wr_i && (sw_addr_i == REG_CTRL);
    assign sw_op      = sw_wdata_i[2:0];
    assign idle_ok    = (state == ST_IDLE);
    assign last_write = (step == 3'(UNLOCK_CYCLES - 1)) || (op == OP_ADD_SEC)
                      || (op == OP_SUSPEND) || (op == OP_RESUME);

    // Address and data of the current write step.
    always_comb begin
        cyc_addr = ADDR_UNLOCK1;
        cyc_data = CMD_UNLOCK1;
        unique case (op)
            OP_SUSPEND: begin
                cyc_addr = addr_reg;
                cyc_data = CMD_PROG_SUSP;
            end
            OP_RESUME: begin
                cyc_addr = addr_reg;
                cyc_data = CMD_PROG_RESUME;
            end
            OP_ADD_SEC: begin
                cyc_addr = sect;
                cyc_data = CMD_SECT_ERASE;
            end
            default: begin
                unique case (step)
                    3'd0, 3'd3: begin
                        cyc_addr = ADDR_UNLOCK1;
                        cyc_data = CMD_UNLOCK1;
                    end
                    3'd1, 3'd4: begin
                        cyc_addr = ADDR_UNLOCK2;
                        cyc_data = CMD_UNLOCK2;
                    end
                    3'd2: begin
                        cyc_addr = ADDR_UNLOCK1;
                        cyc_data = CMD_ERASE_SETUP;
                    end
                    default: begin
                        cyc_addr = (op == OP_CHIP) ? ADDR_UNLOCK1 : sect;
                        cyc_data = (op == OP_CHIP) ? CMD_CHIP_ERASE : CMD_SECT_ERASE;
                    end
                endcase
            end
        endcase
    end

    // Next-state logic of the sequencer and pins.
    always_comb begin
        next_state     = state;
        next_op        = op;
        next_step      = step;
        next_cyc       = cyc;
        next_addr_reg  = addr_reg;
        next_sect      = sect;
        next_rdata     = rdata;
        next_fl_addr   = fl_addr_o;
        next_fl_dq     = fl_dq_o;
        next_we_n      = fl_we_n_o;
        next_oe_n      = fl_oe_n_o;
        next_dq_oe     = fl_dq_oe_o;
        next_reset_n   = fl_reset_n_o;
        next_in_window = in_window && !gap_done;
        next_err       = err;
        next_resumed   = resumed;
        gap_load       = 1'b0;
        guard_load     = 1'b0;
        if (sw_wr_i && sw_addr_i == REG_ADDR) begin
            next_addr_reg = sw_wdata_i[AW-1:0];
            next_sect     = sw_wdata_i[AW-1:0];
        end
        unique case (state)
            ST_IDLE: begin
                if (sw_ctrl_wr) begin
                    next_op   = sw_op;
                    next_step = 3'd0;
                    next_cyc  = 8'd0;
                    next_err  = 1'b0;
                    unique case (sw_op)
                        OP_NONE: next_state = ST_IDLE;
                        OP_READ: begin
                            next_state   = ST_READ;
                            next_fl_addr = addr_reg;
                            next_oe_n    = 1'b0;
                        end
                        OP_HWRESET: begin
                            next_state     = ST_RESET;
                            next_reset_n   = 1'b0;
                            next_in_window = 1'b0;
                        end
                        OP_ADD_SEC: begin
                            if (in_window) begin
                                next_state = ST_WRITE;
                            end else begin
                                next_err   = 1'b1;
                            end
                        end
                        OP_SUSPEND: begin
                            if (resumed && !guard_done) begin
                                next_err   = 1'b1;
                            end else begin
                                next_state = ST_WRITE;
                            end
                        end
                        default: next_state = ST_WRITE;
                    endcase
                end
            end
            ST_WRITE: begin
                next_fl_addr = cyc_addr;
                next_fl_dq   = {{(DW-8){1'b0}}, cyc_data};
                next_dq_oe   = 1'b1;
                next_cyc     = cyc + 8'd1;
                if (cyc == 8'd0) begin
                    next_we_n = 1'b0;
                end else if (cyc == 8'(BUS_CYCLES)) begin
                    next_we_n = 1'b1;
                end else if (cyc == 8'(2 * BUS_CYCLES)) begin
                    next_cyc   = 8'd0;
                    next_dq_oe = 1'b0;
                    if (last_write) begin
                        next_state = (op == OP_CHIP) ? ST_BUSY : ST_IDLE;
                        if (op == OP_SECTOR || op == OP_ADD_SEC) begin
                            gap_load       = 1'b1;
                            next_in_window = 1'b1;
                        end
                        if (op == OP_SUSPEND) begin
                            next_in_window = 1'b0;
                            next_resumed   = 1'b0;
                        end
                        if (op == OP_RESUME) begin
                            guard_load   = 1'b1;
                            next_resumed = 1'b1;
                        end
                    end else begin
                        next_step = step + 3'd1;
                    end
                end
            end
            ST_READ: begin
                next_cyc = cyc + 8'd1;
                if (cyc == 8'(BUS_CYCLES + 2)) begin
                    next_rdata = dq_sync;
                    next_oe_n  = 1'b1;
                    next_cyc   = 8'd0;
                    next_state = ST_IDLE;
                end
            end
            ST_RESET: begin
                next_cyc = cyc + 8'd1;
                if (cyc == 8'(RESET_CYCLES)) begin
                    next_reset_n = 1'b1;
                    next_cyc     = 8'd0;
                    next_state   = ST_IDLE;
                end
            end
            ST_BUSY: begin
                // Chip erase ignores commands, so only a reset is taken.
                if (sw_ctrl_wr && sw_op == OP_HWRESET) begin
                    next_state   = ST_RESET;
                    next_reset_n = 1'b0;
                    next_cyc     = 8'd0;
                end else if (ready_sync) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    // Registers the sequencer and pins.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state        <= ST_IDLE;
            op           <= OP_NONE;
            step         <= 3'd0;
            cyc          <= 8'd0;
            addr_reg     <= '0;
            sect         <= '0;
            rdata        <= '0;
            fl_addr_o    <= '0;
            fl_dq_o      <= '0;
            fl_we_n_o    <= 1'b1;
            fl_oe_n_o    <= 1'b1;
            fl_dq_oe_o   <= 1'b0;
            fl_reset_n_o <= 1'b1;
            in_window    <= 1'b0;
            err          <= 1'b0;
            resumed      <= 1'b0;
        end else if (ce_i) begin
            state        <= next_state;
            op           <= next_op;
            step         <= next_step;
            cyc          <= next_cyc;
            addr_reg     <= next_addr_reg;
            sect         <= next_sect;
            rdata        <= next_rdata;
            fl_addr_o    <= next_fl_addr;
            fl_dq_o      <= next_fl_dq;
            fl_we_n_o    <= next_we_n;
            fl_oe_n_o    <= next_oe_n;
            fl_dq_oe_o   <= next_dq_oe;
            fl_reset_n_o <= next_reset_n;
            in_window    <= next_in_window;
            err          <= next_err;
            resumed      <= next_resumed;
        end
    end

    assign fl_ce_n_o = idle_ok && fl_we_n_o && fl_oe_n_o;

    // ======================================================================
    // Software read port.
    logic [31:0] next_sw_rdata;

    // Selects the register read; data stands one cycle later.
    always_comb begin
        next_sw_rdata = 32'h0000_0000;
        if (sw_rd_i) begin
            unique case (sw_addr_i)
                REG_CTRL:   next_sw_rdata = {29'h0, op};
                REG_ADDR:   next_sw_rdata = 32'(addr_reg);
                REG_STATUS: next_sw_rdata = {26'h0, resumed, guard_done, err, in_window,
                                             ready_sync, !idle_ok};
                REG_RDATA:  next_sw_rdata = 32'(rdata);
                default:    next_sw_rdata = 32'h0000_0000;
            endcase
        end
    end

    // Registers read data.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sw_rdata_o <= 32'h0000_0000;
        end else if (ce_i) begin
            sw_rdata_o <= next_sw_rdata;
        end
    end

    // ======================================================================
    // Checks.
    a_suspend_code: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (state == ST_WRITE && op == OP_SUSPEND && !fl_we_n_o) |-> fl_dq_o[7:0] == CMD_PROG_SUSP)
        else $error("Suspend write not 51h.");
    a_resume_code: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (state == ST_WRITE && op == OP_RESUME && !fl_we_n_o) |-> fl_dq_o[7:0] == CMD_PROG_RESUME)
        else $error("Resume write not 50h.");
    a_guard_kept: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (ce_i && sw_ctrl_wr && sw_op == OP_SUSPEND && idle_ok && resumed && !guard_done)
        |=> (state == ST_IDLE && err))
        else $error("Suspend sent inside guard interval.");
    a_chip_last: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (state == ST_WRITE && op == OP_CHIP && step == 3'd5 && !fl_we_n_o)
        |-> fl_dq_o[7:0] == CMD_CHIP_ERASE && fl_addr_o == AW'(ADDR_UNLOCK1))
        else $error("Chip erase final cycle wrong.");
    a_sect_last: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (state == ST_WRITE && op == OP_SECTOR && step == 3'd5 && !fl_we_n_o)
        |-> fl_dq_o[7:0] == CMD_SECT_ERASE && fl_addr_o == sect)
        else $error("Sector erase final cycle wrong.");
    a_unlock_first: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (state == ST_WRITE && (op == OP_CHIP || op == OP_SECTOR) && step == 3'd0 && !fl_we_n_o)
        |-> fl_dq_o[7:0] == CMD_UNLOCK1)
        else $error("First unlock cycle wrong.");
    a_window_add: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (ce_i && idle_ok && sw_ctrl_wr && sw_op == OP_ADD_SEC && !in_window) |=> err)
        else $error("Sector added outside window.");
    a_reset_pulse: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $fell(fl_reset_n_o) && ce_i |=> !fl_reset_n_o)
        else $error("Reset pulse too short.");
endmodule

// ### verification/fses_flash_model.sv
// Behavioural flash device facing the host sequencer.
`timescale 1ns/10ps
module fses_flash_model #(
    parameter int ERASE_T = 100
) (
    input  wire logic        clk_i,
    input  wire logic [21:0] addr_i,
    input  wire logic [15:0] dq_i,
    input  wire logic        we_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        ce_n_i,
    input  wire logic        reset_n_i,
    output logic      [15:0] dq_o,
    output logic             ready_o
);
    logic [21:0] la [0:63];
    logic [7:0]  ld [0:63];
    logic [15:0] last;
    logic        tog;
    logic        rst_seen;
    logic        kick;
    logic        kick_seen;
    int          nw;
    int          cnt;
    initial begin
        nw = 0;
        cnt = 0;
        tog = 1'b0;
        kick = 1'b0;
        kick_seen = 1'b0;
        rst_seen = 1'b0;
        last = 16'h0000;
    end
    // Each write is taken at the rising strobe edge; a full erase sequence asks for a start.
    always @(posedge we_n_i) begin
        if (!ce_n_i && reset_n_i && nw < 64) begin
            la[nw] = addr_i;
            ld[nw] = dq_i[7:0];
            nw = nw + 1;
            if (nw >= 6 && ld[nw-4] == 8'h80 && (ld[nw-1] == 8'h10 || ld[nw-1] == 8'h30)) begin
                kick = ~kick;
            end
        end
    end
    // Erase time runs down; a start is taken only when idle; hardware reset ends it at once.
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt = 0;
            kick_seen = kick;
            rst_seen = 1'b1;
        end else if (kick != kick_seen) begin
            kick_seen = kick;
            if (cnt == 0) begin
                cnt = ERASE_T;
            end
        end else if (cnt > 0) begin
            cnt = cnt - 1;
        end
    end
    // Status bits toggle once per read while busy.
    always @(negedge oe_n_i) begin
        if (cnt > 0) begin
            tog = ~tog;
        end
    end
    // Remembers the last word driven, sampled while the bus is still driven.
    always @(posedge clk_i) begin
        if (!oe_n_i && !ce_n_i) begin
            last = dq_o;
        end
    end
    assign ready_o = (cnt == 0);
    // Released bus shows the inverse of the last value so stale data never matches.
    assign dq_o = (oe_n_i || ce_n_i) ? ~last
                : (cnt > 0) ? {8'h00, 1'b0, tog, 2'b00, 1'b1, tog, 2'b00}
                : (addr_i[15:0] ^ 16'h5a5a);
endmodule

// ### verification/testbench.sv
// Self-checking bench for the flash host sequencer.
`timescale 1ns/10ps
module testbench;
    import fses_pkg::*;
    logic        sys_clk, rst, ce, sw_wr, sw_rd, fl_dq_oe, fl_we_n, fl_oe_n, fl_ce_n;
    logic        fl_reset_n, fl_ready;
    logic [3:0]  sw_addr;
    logic [31:0] sw_wdata, sw_rdata, v;
    logic [21:0] fl_addr;
    logic [15:0] fl_dq_o, fm_dq;
    int          n_fail, checks_done, base;
    fses_host #(.SECT_GAP(100), .RES_GUARD(20)) dut (.sys_clk_i(sys_clk), .rst_i(rst), .ce_i(ce),
        .sw_addr_i(sw_addr), .sw_wdata_i(sw_wdata), .sw_wr_i(sw_wr), .sw_rd_i(sw_rd),
        .sw_rdata_o(sw_rdata), .fl_addr_o(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe),
        .fl_dq_i(fl_dq_oe ? fl_dq_o : fm_dq), .fl_we_n_o(fl_we_n), .fl_oe_n_o(fl_oe_n),
        .fl_ce_n_o(fl_ce_n), .fl_reset_n_o(fl_reset_n), .fl_ready_i(fl_ready));
    fses_flash_model fm (.clk_i(sys_clk), .addr_i(fl_addr), .dq_i(fl_dq_o), .we_n_i(fl_we_n),
        .oe_n_i(fl_oe_n), .ce_n_i(fl_ce_n), .reset_n_i(fl_reset_n), .dq_o(fm_dq), .ready_o(fl_ready));
    always #2.5 sys_clk = ~sys_clk;
    // Verdict and end of run.
    task end_sim;
        if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk) begin sw_addr <= a; sw_wdata <= d; sw_wr <= 1'b1; end
        @(posedge sys_clk) sw_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge sys_clk) begin sw_addr <= a; sw_rd <= 1'b1; end
        @(posedge sys_clk) sw_rd <= 1'b0;
        #1 v = sw_rdata;
    endtask
    // Polls one status bit until it reaches a level, with a bounded count.
    task poll(input int b, input logic lv);
        for (int i = 0; i < 600; i++) begin
            rd(REG_STATUS);
            if (v[b] === lv) return;
        end
        n_fail++;
        end_sim();
    endtask
    task chk_seq(input logic [21:0] a6, input logic [7:0] d6);
        logic [21:0] ea [0:5];
        logic [7:0]  ed [0:5];
        ea = '{ADDR_UNLOCK1, ADDR_UNLOCK2, ADDR_UNLOCK1, ADDR_UNLOCK1, ADDR_UNLOCK2, a6};
        ed = '{CMD_UNLOCK1, CMD_UNLOCK2, CMD_ERASE_SETUP, CMD_UNLOCK1, CMD_UNLOCK2, d6};
        for (int i = 0; i < 6; i++) chk({fm.la[base+i], fm.ld[base+i]}, {ea[i], ed[i]});
    endtask
    // Chip erase: six cycles, waits for the device to finish.
    task t_chip;
        base = fm.nw;
        wr(REG_CTRL, {29'h0, OP_CHIP});
        poll(1, 1'b0);
        poll(0, 1'b0);
        chk({fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n}, 4'h7);
        chk_seq(ADDR_UNLOCK1, CMD_CHIP_ERASE);
        chk(32'(fm.nw - base), 32'h6);
        chk(fl_ready, 1'b1);
    endtask
    // Sector erase with one extra sector added inside the window.
    task t_sector;
        base = fm.nw;
        wr(REG_ADDR, 32'h0001_0000);
        wr(REG_CTRL, {29'h0, OP_SECTOR});
        poll(2, 1'b1);
        wr(REG_ADDR, 32'h0002_0000);
        wr(REG_CTRL, {29'h0, OP_ADD_SEC});
        poll(0, 1'b0);
        chk_seq(22'h010000, CMD_SECT_ERASE);
        chk({fm.la[base+6], fm.ld[base+6]}, {22'h020000, CMD_SECT_ERASE});
        wr(REG_CTRL, {29'h0, OP_SUSPEND});
        poll(0, 1'b0);
        rd(REG_STATUS);
        chk(v[2], 1'b0);
        poll(1, 1'b1);
    endtask
    // Suspend, resume, early suspend refused, later suspend accepted.
    task t_susp;
        base = fm.nw;
        wr(REG_CTRL, {29'h0, OP_SUSPEND});
        poll(0, 1'b0);
        wr(REG_CTRL, {29'h0, OP_RESUME});
        poll(0, 1'b0);
        wr(REG_CTRL, {29'h0, OP_SUSPEND});
        rd(REG_STATUS);
        chk(v[3], 1'b1);
        chk(32'(fm.nw - base), 32'h2);
        chk({fm.ld[base], fm.ld[base+1]}, {CMD_PROG_SUSP, CMD_PROG_RESUME});
        poll(4, 1'b1);
        wr(REG_CTRL, {29'h0, OP_SUSPEND});
        ce <= 1'b0;
        repeat (60) @(posedge sys_clk);
        chk(32'(fm.nw - base), 32'h2);
        ce <= 1'b1;
        poll(0, 1'b0);
        chk(fm.ld[base+2], CMD_PROG_SUSP);
    endtask
    // Hardware reset in mid chip erase, then an array read and an unmapped read.
    task t_reset_read;
        wr(REG_CTRL, {29'h0, OP_CHIP});
        poll(1, 1'b0);
        // Let the last write cycle finish so the reset order meets the busy state.
        repeat (2 * BUS_CYCLES) @(posedge sys_clk);
        wr(REG_CTRL, {29'h0, OP_HWRESET});
        poll(0, 1'b0);
        chk({fm.rst_seen, fl_ready}, 2'b11);
        wr(REG_ADDR, 32'h0000_0123);
        rd(REG_ADDR);
        chk(v, 32'h0000_0123);
        wr(REG_CTRL, {29'h0, OP_READ});
        poll(0, 1'b0);
        rd(REG_RDATA);
        chk(v, 32'h0000_5b79);
        rd(4'hf);
        chk(v, 32'h0);
        wr(REG_CTRL, {29'h0, OP_ADD_SEC});
        rd(REG_STATUS);
        chk(v[3:2], 2'b10);
    endtask
    initial begin
        {sys_clk, sw_wr, sw_rd, sw_addr, sw_wdata, n_fail, checks_done} = '0;
        ce = 1'b1;
        rst = 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        t_chip();
        t_sector();
        t_susp();
        t_reset_read();
        end_sim();
    end
endmodule
